// ---- design/tmc_timer.v ----
// sixteen-bit timer/counter with control, count, status and mask registers
//
// Overview of operation
// RQ1: oscillator enable high runs the timer oscillator; low switches its inverter off.
// RQ2: external source: sync bypass 1 counts raw edges, 0 synchronises them first.
// RQ3: internal source selected: sync bypass ignored, count instruction clock.
// RQ4: source select 1 counts external rising edges; 0 counts instruction cycles.
// RQ5: run bit 1 enables counting; 0 halts and holds the count.
// RQ6: asynchronous mode increments straight from external edges, no instruction phasing.
// RQ7: asynchronous mode keeps counting in sleep; enabled overflow wakes the processor.
// RQ8: asynchronous mode count is not offered as capture/compare time base.
// RQ9: byte reads while counting asynchronously always return a valid value.
// RQ10: software reads high, low, high again and retries on a mismatch.
// RQ11: software should stop the counter before writing the count bytes.
// RQ12: count wraps all ones to zero and sets overflow; enable gates interrupt.
// RQ13: prescale select 11 divides by 8, 10 by 4, 01 by 2, 00 by 1.
// RQ14: timer mode advances once per instruction cycle; counter mode per rising edge.
// RQ15: oscillator enabled forces both pins to inputs and their port bits read zero.
// RQ16: prescaler output is the single count enable; low carries into high.
`timescale 1ns/1ns
`default_nettype none
`include "tmc_regs.vh"
module tmc_timer (
  input wire core_clk,
  input wire rstn,
  input wire [`TMC_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire external_count_clock_pin,
  input wire sleep_mode,
  input wire [1:0] osc_pin_dir_out,
  input wire [1:0] osc_pin_level,
  output reg [1:0] osc_pin_oe,
  output reg [1:0] osc_pin_read,
  output reg osc_run,
  output reg timebase_valid,
  output reg [15:0] timebase_count,
  output reg irq,
  output reg wake_req
);

  ////////////////////////////////////////////////////////////////////////
  // reset release

  reg rst_meta_n;
  reg rst_n;

  // asynchronous assert, release through two flops
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and decode

  reg [7:0] timer_one_control;
  reg [15:0] count;
  reg [7:0] status;
  reg [7:0] mask;
  reg [1:0] instr_phase;

  wire run_control_bit;
  wire clock_source_select;
  wire sync_bypass_bit;
  wire osc_enable_bit;
  wire [1:0] prescale_select;
  wire async_mode;
  wire wr_ctl;
  wire wr_low;
  wire wr_high;
  wire rd_status;

  assign run_control_bit = timer_one_control[`TMC_CTL_RUN];
  assign clock_source_select = timer_one_control[`TMC_CTL_SRC];
  assign sync_bypass_bit = timer_one_control[`TMC_CTL_SYNC_BYP];
  assign osc_enable_bit = timer_one_control[`TMC_CTL_OSC_EN];
  assign prescale_select = timer_one_control[`TMC_CTL_PS_HI:`TMC_CTL_PS_LO];

  // bypass only counts when the external source is chosen
  assign async_mode = clock_source_select & sync_bypass_bit; // see RQ3

  assign wr_ctl = reg_wr & (reg_addr == `TMC_OFF_CONTROL);
  assign wr_low = reg_wr & (reg_addr == `TMC_OFF_COUNT_LOW);
  assign wr_high = reg_wr & (reg_addr == `TMC_OFF_COUNT_HIGH);
  assign rd_status = reg_rd & (reg_addr == `TMC_OFF_STATUS);

  ////////////////////////////////////////////////////////////////////////
  // tick sources

  wire ext_rise;
  wire int_tick;
  wire src_tick;
  wire count_en;
  wire count_allowed;

  // external edges, synchronised or raw as the bypass bit asks
  tmc_edge_sync u_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din(external_count_clock_pin),
    .bypass(async_mode), // see RQ2
    .rise(ext_rise)
  );

  // instruction cycle strobe, one core clock in four
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_phase <= 2'h0;
    end else begin
      instr_phase <= instr_phase + 2'h1;
    end
  end

  assign int_tick = (instr_phase == `TMC_INSTR_DIV);

  // raw external edges skip the instruction phase entirely in async mode
  assign src_tick = clock_source_select ? ext_rise : int_tick; // see RQ4 see RQ14 see RQ6

  // sleep stops the instruction clock, so only async counting survives it
  assign count_allowed = run_control_bit & (~sleep_mode | async_mode); // see RQ5 see RQ7

  // prescaler output is the one and only increment enable
  tmc_prescale u_prescale (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ratio_sel(prescale_select), // see RQ13
    .tick(src_tick & count_allowed),
    .clear(wr_low | wr_high),
    .count_en(count_en)
  );

  ////////////////////////////////////////////////////////////////////////
  // control and mask registers

  // unimplemented control bits stay zero
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_one_control <= `TMC_CONTROL_RST;
      mask <= `TMC_MASK_RST;
    end else begin
      if (wr_ctl) begin
        timer_one_control <= reg_wdata & `TMC_CTL_WMASK;
      end
      if (reg_wr & (reg_addr == `TMC_OFF_MASK)) begin
        mask <= reg_wdata & `TMC_STAT_WMASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter

  wire [15:0] count_inc;
  wire wrap;

  // one sixteen-bit add: low byte carry reaches the high byte in the same event
  assign count_inc = count + 16'h0001; // see RQ16
  assign wrap = count_en & (count == 16'hffff); // see RQ12

  // a byte write wins over a same-cycle increment; the other byte holds,
  // which is why software should stop the counter before writing
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= `TMC_COUNT_RST;
    end else if (wr_low | wr_high) begin
      if (wr_low) begin
        count[7:0] <= reg_wdata; // see RQ11
      end
      if (wr_high) begin
        count[15:8] <= reg_wdata;
      end
    end else if (count_en) begin
      count <= count_inc; // see RQ12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status and interrupt

  reg [7:0] next_status;

  // sticky overflow; a wrap in the same cycle as the clearing read wins
  always @* begin
    next_status = status;
    if (rd_status) begin
      next_status = `TMC_STATUS_RST;
    end
    if (wrap) begin
      next_status[`TMC_STAT_OVF] = 1'b1; // see RQ12
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= `TMC_STATUS_RST;
      irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(next_status & mask); // see RQ12
      // only an async-mode overflow can occur while asleep
      wake_req <= sleep_mode & (|(next_status & mask)); // see RQ7
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port

  // the counter lives in the core clock domain, so any byte read is coherent
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `TMC_OFF_CONTROL: reg_rdata <= timer_one_control;
        `TMC_OFF_COUNT_LOW: reg_rdata <= count[7:0]; // see RQ9
        `TMC_OFF_COUNT_HIGH: reg_rdata <= count[15:8]; // see RQ9
        `TMC_OFF_STATUS: reg_rdata <= status;
        `TMC_OFF_MASK: reg_rdata <= mask;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator, pins and capture time base

  // oscillator overrides pin direction and masks the port read
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_run <= 1'b0;
      osc_pin_oe <= 2'h0;
      osc_pin_read <= 2'h0;
      timebase_valid <= 1'b0;
      timebase_count <= 16'h0000;
    end else begin
      osc_run <= osc_enable_bit; // see RQ1
      osc_pin_oe <= osc_enable_bit ? 2'h0 : osc_pin_dir_out; // see RQ15
      osc_pin_read <= osc_enable_bit ? 2'h0 : osc_pin_level; // see RQ15
      // capture and compare must not use an async count
      timebase_valid <= ~async_mode; // see RQ8
      timebase_count <= async_mode ? 16'h0000 : count; // see RQ8
    end
  end

endmodule
`default_nettype wire

// ---- design/tmc_regs.vh ----
// register offsets, field positions, reset values and timing counts of the timer/counter
`ifndef TMC_REGS_VH
`define TMC_REGS_VH

// register offsets on the plain register port
`define TMC_ADDR_W 3
`define TMC_OFF_CONTROL 3'h0
`define TMC_OFF_COUNT_LOW 3'h1
`define TMC_OFF_COUNT_HIGH 3'h2
`define TMC_OFF_STATUS 3'h3
`define TMC_OFF_MASK 3'h4

// control register fields
`define TMC_CTL_RUN 0
`define TMC_CTL_SRC 1
`define TMC_CTL_SYNC_BYP 2
`define TMC_CTL_OSC_EN 3
`define TMC_CTL_PS_LO 4
`define TMC_CTL_PS_HI 5
`define TMC_CTL_WMASK 8'h3f

// status and mask fields
`define TMC_STAT_OVF 0
`define TMC_STAT_WMASK 8'h01

// reset values
`define TMC_CONTROL_RST 8'h00
`define TMC_COUNT_RST 16'h0000
`define TMC_STATUS_RST 8'h00
`define TMC_MASK_RST 8'h00

// the instruction cycle is four core clocks
`define TMC_INSTR_DIV 2'h3

`endif

// ---- design/tmc_prescale.v ----
// input clock prescaler giving one count enable per 1, 2, 4 or 8 input ticks
`timescale 1ns/1ns
`default_nettype none
module tmc_prescale (
  input wire core_clk,
  input wire rst_n,
  input wire [1:0] ratio_sel,
  input wire tick,
  input wire clear,
  output wire count_en
);
  reg [2:0] div_cnt;
  reg [2:0] terminal;

  // terminal count from the select field, 00 gives divide by one
  always @* begin
    case (ratio_sel)
      2'h0: terminal = 3'h0;
      2'h1: terminal = 3'h1;
      2'h2: terminal = 3'h3;
      2'h3: terminal = 3'h7;
      default: terminal = 3'h0;
    endcase
  end

  assign count_en = tick & (div_cnt == terminal);

  // a counter write clears the prescaler so the new value runs a full period
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 3'h0;
    end else if (clear) begin
      div_cnt <= 3'h0;
    end else if (tick) begin
      if (div_cnt == terminal) begin
        div_cnt <= 3'h0;
      end else begin
        div_cnt <= div_cnt + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/tmc_edge_sync.v ----
// rising edge detector for the external count input, synchronised or bypassed
`timescale 1ns/1ns
`default_nettype none
module tmc_edge_sync (
  input wire core_clk,
  input wire rst_n,
  input wire din,
  input wire bypass,
  output wire rise
);
  reg sync_a;
  reg sync_b;
  reg sync_last;
  reg raw_last;

  // two-stage synchroniser plus history flops; sync_a feeds only sync_b
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_last <= 1'b0;
      raw_last <= 1'b0;
    end else begin
      sync_a <= din;
      sync_b <= sync_a;
      sync_last <= sync_b;
      raw_last <= din;
    end
  end

  // bypass trades metastability margin for two cycles less latency
  assign rise = bypass ? (din & ~raw_last) : (sync_b & ~sync_last);
endmodule
`default_nettype wire

// ---- verif/tmc_ext_src.sv ----
// far-side external count clock that stands low while disabled
`timescale 1ns/1ns
`default_nettype none
module tmc_ext_src (
  input wire logic en,
  output var logic clk_out,
  output var int rises
);
  // a 45 ns half period keeps every edge clear of the core sampling edge, so the
  // synchronous pin input never races the clock that samples it
  initial begin
    clk_out = 1'b0;
    rises = 0;
    forever begin
      if (en) begin
        #45 clk_out = 1'b1;
        rises++;
        #45 clk_out = 1'b0;
      end else begin
        #1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/tmc_timer_chk.sv ----
// port assertions for the timer/counter
`timescale 1ns/1ns
`default_nettype none
module tmc_timer_chk (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic sleep_mode,
  input wire logic [1:0] osc_pin_oe,
  input wire logic [1:0] osc_pin_read,
  input wire logic osc_run,
  input wire logic timebase_valid,
  input wire logic [15:0] timebase_count,
  input wire logic irq,
  input wire logic wake_req
);
  logic [2:0] wr_hist;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // writes of the last three edges; a control write takes that long to reach outputs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) wr_hist <= 3'h0;
    else wr_hist <= {wr_hist[1:0], reg_wr};
  end
  ////////////////////////////////////////
  sequence s_asleep;
    (sleep_mode && !reg_wr) [*3];
  endsequence
  property p_osc_pins; osc_run |-> osc_pin_oe == 2'h0 && osc_pin_read == 2'h0; endproperty
  a_osc_pins: assert property (p_osc_pins) else $error("osc pins not released");
  property p_osc_cause; $changed(osc_run) |-> wr_hist != 3'h0; endproperty
  a_osc_cause: assert property (p_osc_cause) else $error("osc moved alone");
  property p_rd_data; reg_rdata != 8'h00 |-> $past(reg_rd); endproperty
  a_rd_data: assert property (p_rd_data) else $error("stray read data");
  property p_wake; wake_req |-> irq && $past(sleep_mode); endproperty
  a_wake: assert property (p_wake) else $error("wake without cause");
  property p_base_off; !timebase_valid |-> timebase_count == 16'h0000; endproperty
  a_base_off: assert property (p_base_off) else $error("time base leaked");
  property p_base_mode; $fell(timebase_valid) |-> wr_hist != 3'h0; endproperty
  a_base_mode: assert property (p_base_mode) else $error("mode moved alone");
  property p_irq_drop; $fell(irq) |-> $past(reg_rd) || wr_hist[1:0] != 2'h0; endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq dropped alone");
  property p_carry;
    timebase_valid && wr_hist == 3'h0 && $changed(timebase_count[15:8])
      |-> timebase_count[7:0] == 8'h00;
  endproperty
  a_carry: assert property (p_carry) else $error("high byte moved without carry");
  property p_sleep_hold; s_asleep |=> $stable(timebase_count); endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("time base ran in sleep");
endmodule
bind tmc_timer tmc_timer_chk u_chk (.core_clk, .rstn, .reg_wr, .reg_rd, .reg_rdata, .sleep_mode,
  .osc_pin_oe, .osc_pin_read, .osc_run, .timebase_valid, .timebase_count, .irq, .wake_req);
`default_nettype wire

// ---- verif/sixteen_bit_timer_counter_bench.sv ----
// self-checking bench of the timer/counter with an external clock source
`timescale 1ns/1ns
`default_nettype none
`include "tmc_regs.vh"
module sixteen_bit_timer_counter_bench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_mode = 1'b0;
  logic ext_en = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0] osc_pin_dir_out = 2'h1;
  logic [1:0] osc_pin_level = 2'h2;
  logic [7:0] reg_rdata;
  logic [1:0] osc_pin_oe;
  logic [1:0] osc_pin_read;
  logic external_count_clock_pin, osc_run, timebase_valid, irq, wake_req;
  logic [15:0] timebase_count;
  int ext_rises;
  int bad_count = 0;
  int num_checks = 0;
  tmc_timer u_dut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .external_count_clock_pin, .sleep_mode, .osc_pin_dir_out, .osc_pin_level, .osc_pin_oe,
    .osc_pin_read, .osc_run, .timebase_valid, .timebase_count, .irq, .wake_req);
  tmc_ext_src u_src (.en(ext_en), .clk_out(external_count_clock_pin), .rises(ext_rises));
  // 100 MHz core clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // phase of the free-running tick is unknown, so counts get a window
  task automatic chk_rng(input string what, input logic [15:0] lo, input logic [15:0] got);
    num_checks++;
    if ((got >= lo && got <= lo + 16'h0002) !== 1'b1) begin
      bad_count++;
      $display("ERROR %s expected %h+2 seen %h", what, lo, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // high, low, high again; a carry between them forces a fresh read of both bytes
  task automatic rd16(output logic [15:0] v);
    logic [7:0] h, l;
    rd(`TMC_OFF_COUNT_HIGH, h);
    rd(`TMC_OFF_COUNT_LOW, l);
    rd(`TMC_OFF_COUNT_HIGH, v[15:8]);
    if (h !== v[15:8]) begin
      rd(`TMC_OFF_COUNT_HIGH, v[15:8]);
      rd(`TMC_OFF_COUNT_LOW, l);
    end
    v[7:0] = l;
  endtask
  task automatic set16(input logic [15:0] v);
    wr(`TMC_OFF_CONTROL, 8'h00);
    wr(`TMC_OFF_COUNT_LOW, v[7:0]);
    wr(`TMC_OFF_COUNT_HIGH, v[15:8]);
  endtask
  task automatic pulses(input int n);
    int t;
    t = ext_rises + n;
    ext_en <= 1'b1;
    for (int i = 0; i < 2000 && ext_rises < t; i++) @(posedge core_clk);
    ext_en <= 1'b0;
    repeat (20) @(posedge core_clk);
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] d;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], d);
      chk("reset value", 16'h0000, {8'h00, d});
    end
    wr(`TMC_OFF_CONTROL, 8'hc8);
    rd(`TMC_OFF_CONTROL, d);
    chk("control", 16'h0008, {8'h00, d});
    chk("osc pins", 16'h0010, {11'h000, osc_run, osc_pin_oe, osc_pin_read});
    wr(`TMC_OFF_CONTROL, 8'h00);
    wr(3'h6, 8'hff);
    rd(3'h6, d);
    chk("unmapped", 16'h0000, {8'h00, d});
    chk("osc pins", 16'h0006, {11'h000, osc_run, osc_pin_oe, osc_pin_read});
  endtask
  // sync bypass set with internal source must not matter
  task automatic t_prescale;
    logic [15:0] v, w;
    for (int p = 0; p < 4; p++) begin
      set16(16'h0000);
      wr(`TMC_OFF_CONTROL, {2'h0, p[1:0], 4'h5});
      repeat (32 << p) @(posedge core_clk);
      wr(`TMC_OFF_CONTROL, 8'h00);
      rd16(v);
      chk_rng("prescaled count", 16'h0007, v);
      repeat (40) @(posedge core_clk);
      rd16(w);
      chk("held count", v, w);
      chk("time base", v, timebase_count);
    end
  endtask
  task automatic t_overflow;
    logic [7:0] d;
    for (int m = 1; m >= 0; m--) begin
      wr(`TMC_OFF_MASK, m[7:0]);
      set16(16'hfffe);
      wr(`TMC_OFF_CONTROL, 8'h01);
      repeat (20) @(posedge core_clk);
      wr(`TMC_OFF_CONTROL, 8'h00);
      chk("irq", m[15:0], {15'h0000, irq});
      rd(`TMC_OFF_COUNT_HIGH, d);
      chk("high after wrap", 16'h0000, {8'h00, d});
      rd(`TMC_OFF_STATUS, d);
      chk("status", 16'h0001, {8'h00, d});
      rd(`TMC_OFF_STATUS, d);
      chk("status cleared", 16'h0000, {8'h00, d});
      chk("irq cleared", 16'h0000, {15'h0000, irq});
    end
  endtask
  // synchronised then raw external edges; the raw pass runs asleep
  task automatic t_ext;
    logic [7:0] d;
    logic [15:0] v;
    wr(`TMC_OFF_MASK, 8'h01);
    for (int b = 0; b < 2; b++) begin
      set16(16'hfff6);
      wr(`TMC_OFF_CONTROL, b[0] ? 8'h07 : 8'h03);
      sleep_mode <= b[0];
      pulses(10);
      chk("wake", {15'h0000, b[0]}, {15'h0000, wake_req});
      chk("valid", {15'h0000, !b[0]}, {15'h0000, timebase_valid});
      sleep_mode <= 1'b0;
      rd16(v);
      chk("external count", 16'h0000, v);
      rd(`TMC_OFF_STATUS, d);
      chk("status", 16'h0001, {8'h00, d});
      wr(`TMC_OFF_CONTROL, 8'h00);
    end
  endtask
  // instruction-clock counting must freeze in sleep; only the raw external path survives
  task automatic t_sleep;
    logic [15:0] v;
    set16(16'h1234);
    wr(`TMC_OFF_CONTROL, 8'h01);
    sleep_mode <= 1'b1;
    repeat (40) @(posedge core_clk);
    rd16(v);
    chk("count in sleep", 16'h1234, v);
    chk("wake in sleep", 16'h0000, {15'h0000, wake_req});
    wr(`TMC_OFF_CONTROL, 8'h00);
    sleep_mode <= 1'b0;
  endtask
  ////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // the run needs some 1150 cycles; a hang is cut off well past that
  initial begin
    #300000;
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs;
    t_prescale;
    t_overflow;
    t_ext;
    t_sleep;
    stop_test;
  end
endmodule
`default_nettype wire
